// File: pmcr_pkg.sv
// package: constants and types for the port phy control register block
package pmcr_pkg;
  // port set
  localparam int NPORT = 5; // ports with a control word
  localparam int PW = 3; // port index width
  localparam logic [4:0] PHYAD_FIRST = 5'h01; // address of port one
  localparam logic [4:0] PHYAD_LAST = 5'h05; // highest accepted address
  // management register addresses
  localparam logic [4:0] REG_CTRL = 5'h00; // control word
  localparam logic [4:0] REG_STD_LAST = 5'h05; // last of the low group
  localparam logic [4:0] REG_VEND_A = 5'h1d; // first vendor register
  localparam logic [4:0] REG_VEND_B = 5'h1f; // second vendor register
  // control word bit positions
  localparam int B_SRST = 15; // soft reset, self clearing
  localparam int B_LOOP = 14; // mac loopback
  localparam int B_F100 = 13; // forced speed
  localparam int B_ANEN = 12; // autoneg_on
  localparam int B_PDN = 11; // power down
  localparam int B_ISO = 10; // line_isolation
  localparam int B_ANRR = 9; // autoneg_rerun
  localparam int B_FDX = 8; // forced duplex
  localparam int B_COLT = 7; // collision test, not supported
  localparam int B_RSVD = 6; // reserved
  localparam int B_XSEL = 5; // crossover_style_select
  // control word reset values
  localparam logic RST_LOOP = 1'b0;
  localparam logic RST_F100 = 1'b1;
  localparam logic RST_ANEN = 1'b1;
  localparam logic RST_PDN = 1'b0;
  localparam logic RST_ISO = 1'b0;
  localparam logic RST_ANRR = 1'b0;
  localparam logic RST_FDX = 1'b0;
  localparam logic RST_XSEL = 1'b1;
  // serial management frame
  localparam logic [5:0] PRE_ONES = 6'h20; // preamble ones needed
  localparam logic [1:0] ST_CODE = 2'b01; // start of frame
  localparam logic [1:0] OP_RD = 2'b10; // read opcode
  localparam logic [1:0] OP_WR = 2'b01; // write opcode
  localparam logic [5:0] HDR_LAST = 6'h0d; // 14 header bits
  localparam logic [5:0] TA_LAST = 6'h01; // 2 turnaround bits
  localparam logic [5:0] DAT_LAST = 6'h0f; // 16 data bits
  // spi frame: command byte, address byte, 16 data bits
  localparam logic [7:0] CMD_WR = 8'h02;
  localparam logic [7:0] CMD_RD = 8'h03;
  localparam logic [5:0] SPI_HDR_LAST = 6'h0f;
  localparam logic [5:0] SPI_DAT_LAST = 6'h1f;
  localparam logic [5:0] SPI_ALL = 6'h20;
  localparam logic [2:0] IDX_VEND_A = 3'h6; // spi index of REG_VEND_A
  localparam logic [2:0] IDX_VEND_B = 3'h7; // spi index of REG_VEND_B
  // soft reset hold time
  localparam int CLK_MHZ = 200;
  localparam int SRST_NS = 1000;
  localparam int SRST_CYC = (SRST_NS * CLK_MHZ + 999) / 1000;
  localparam int SRST_W = 8;
  // serial management receiver states
  typedef enum logic [1:0] {
    MS_PRE = 2'b00,
    MS_HDR = 2'b01,
    MS_TA = 2'b10,
    MS_DAT = 2'b11
  } pmcr_mdio_st_t;
  // register addresses that a port answers
  function automatic logic reg_known(input logic [4:0] rg);
    return (rg <= REG_STD_LAST) || (rg == REG_VEND_A) || (rg == REG_VEND_B);
  endfunction : reg_known
  // spi index to management address
  function automatic logic [4:0] spi_idx_to_reg(input logic [2:0] idx);
    logic [4:0] r;
    r = {2'b00, idx};
    if (idx == IDX_VEND_A) r = REG_VEND_A;
    if (idx == IDX_VEND_B) r = REG_VEND_B;
    return r;
  endfunction : spi_idx_to_reg
endpackage : pmcr_pkg

// File: pmcr_mdio_slave.sv
// serial management frame receiver and read shifter
`timescale 1ns/1ps
module pmcr_mdio_slave (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic mdc_i, // management clock pin
  input wire logic mdio_i, // management data pin level
  output logic mdio_o, // data driven on the pin
  output logic mdio_oe_o, // high while driving the pin
  output logic [4:0] phy_o, // latched port address
  output logic [4:0] reg_o, // latched register address
  input wire logic [15:0] rdata_i, // read word for phy_o and reg_o
  output logic wr_o, // one-cycle write strobe
  output logic [15:0] wdata_o // write word, valid with wr_o
);
  // whole state of the receiver
  typedef struct packed {
    logic [2:0] mdc_s; // [0] first sync flop, [1] second, [2] previous
    logic [1:0] dio_s; // data synchroniser
    pmcr_pkg::pmcr_mdio_st_t st; // frame phase
    logic [5:0] cnt; // bit counter in phase
    logic [15:0] sh; // shift register
    logic rd; // frame is a read
    logic [4:0] phy; // port address
    logic [4:0] rg; // register address
    logic oe; // pin drive enable
    logic dout; // pin drive level
    logic wr; // write strobe
  } pmcr_mdio_q_t;

  localparam pmcr_mdio_q_t RST_Q = '{st: pmcr_pkg::MS_PRE, default: '0};

  pmcr_mdio_q_t q; // registered state
  pmcr_mdio_q_t d; // next state
  logic rise; // mdc rising edge seen
  logic bit_in; // sampled data bit
  logic [13:0] hdr; // header as it completes
  logic hdr_ok; // header addresses this device

  assign rise = q.mdc_s[1] & ~q.mdc_s[2];
  assign bit_in = q.dio_s[1];
  assign hdr = {q.sh[12:0], bit_in};
  // foreign port addresses stay silent so other phys may answer
  assign hdr_ok = (hdr[13:12] == pmcr_pkg::ST_CODE) &&
                  ((hdr[11:10] == pmcr_pkg::OP_RD) || (hdr[11:10] == pmcr_pkg::OP_WR)) &&
                  (hdr[9:5] >= pmcr_pkg::PHYAD_FIRST) && (hdr[9:5] <= pmcr_pkg::PHYAD_LAST) &&
                  pmcr_pkg::reg_known(hdr[4:0]);

  // next state: sample on each mdc rise, change drive just after it
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.mdc_s = {q.mdc_s[1:0], mdc_i};
    d.dio_s = {q.dio_s[0], mdio_i};
    if (rise) begin
      case (q.st)
        pmcr_pkg::MS_PRE: begin
          if (bit_in) begin // count ones, saturating
            if (q.cnt != pmcr_pkg::PRE_ONES) d.cnt = q.cnt + 6'h01;
          end else if (q.cnt == pmcr_pkg::PRE_ONES) begin // first start bit
            d.st = pmcr_pkg::MS_HDR;
            d.cnt = 6'h01;
            d.sh = {15'h0000, bit_in};
          end else begin // short preamble, start over
            d.cnt = '0;
          end
        end
        pmcr_pkg::MS_HDR: begin
          d.sh = {q.sh[14:0], bit_in};
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == pmcr_pkg::HDR_LAST) begin
            d.cnt = '0;
            d.st = hdr_ok ? pmcr_pkg::MS_TA : pmcr_pkg::MS_PRE; // RULE2 RULE3
            d.rd = (hdr[11:10] == pmcr_pkg::OP_RD);
            d.phy = hdr[9:5];
            d.rg = hdr[4:0];
          end
        end
        pmcr_pkg::MS_TA: begin
          d.cnt = q.cnt + 6'h01;
          if (q.cnt != pmcr_pkg::TA_LAST) begin
            if (q.rd) begin // second turnaround bit driven low
              d.oe = 1'b1;
              d.dout = 1'b0;
            end
          end else begin
            d.st = pmcr_pkg::MS_DAT;
            d.cnt = '0;
            if (q.rd) begin // first data bit, msb first
              d.dout = rdata_i[15];
              d.sh = {rdata_i[14:0], 1'b0};
            end
          end
        end
        default: begin // data phase
          d.cnt = q.cnt + 6'h01;
          if (q.rd) begin
            d.dout = q.sh[15];
            d.sh = {q.sh[14:0], 1'b0};
          end else begin
            d.sh = {q.sh[14:0], bit_in};
          end
          if (q.cnt == pmcr_pkg::DAT_LAST) begin // frame ends, release pin
            d.st = pmcr_pkg::MS_PRE;
            d.cnt = '0;
            d.oe = 1'b0;
            d.dout = 1'b0;
            d.wr = ~q.rd;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= RST_Q;
    end else begin
      q <= d;
    end
  end

  assign mdio_o = q.dout;
  assign mdio_oe_o = q.oe;
  assign phy_o = q.phy;
  assign reg_o = q.rg;
  assign wr_o = q.wr;
  assign wdata_o = q.sh;

  a_ta_drive_low: assert property ( // RULE2
    @(posedge clk_i) disable iff (!rst_n_i)
    (rise && q.st == pmcr_pkg::MS_TA && q.cnt == '0 && q.rd) |=> (mdio_oe_o && !mdio_o))
    else $error("read turnaround not driven low");

  a_foreign_silent: assert property ( // RULE2 RULE3
    @(posedge clk_i) disable iff (!rst_n_i)
    (rise && q.st == pmcr_pkg::MS_HDR && q.cnt == pmcr_pkg::HDR_LAST && !hdr_ok)
    |=> (q.st == pmcr_pkg::MS_PRE) ##1 !mdio_oe_o)
    else $error("foreign or unknown address was answered");
endmodule : pmcr_mdio_slave

// File: pmcr_phy_ctrl.sv
// per-port phy control words reached over serial management and spi
// Functional notes
// (RULE1) spi reaches same registers, own address map
// (RULE2) port addresses one to five select ports
// (RULE3) answer only addresses 0-5, 1d, 1f
// (RULE4) bit 15 soft resets port, self clears
// (RULE5) bit 14 loops traffic at mac boundary
// (RULE6) loopback bit works alike on ports 3-5
// (RULE7) bit 13 forces 100 or 10, resets one
// (RULE8) bit 12 enables autonegotiation, resets one
// (RULE9) bit 11 powers the port down
// (RULE10) bit 10 isolates phy from transmit pair
// (RULE11) writing bit 9 restarts autonegotiation
// (RULE12) bit 8 forces full or half duplex
// (RULE13) bit 5 picks crossover scheme, resets one
// (RULE14) bits 7 and 6 read zero always
// (RULE15) soft reset restores defaults before bit clears
`timescale 1ns/1ps
module pmcr_phy_ctrl (
  input wire logic MCLK_I, // 200 mhz system clock
  input wire logic RESETN_I, // synchronous reset, active low
  input wire logic MDC_I, // management clock pin
  input wire logic MDIO_I, // management data pin level
  output logic MDIO_O, // management data drive level
  output logic MDIO_OE_O, // management data drive enable
  input wire logic SPI_SCLK_I, // spi clock pin
  input wire logic SPI_CS_N_I, // spi select pin, active low
  input wire logic SPI_MOSI_I, // spi data in
  output logic SPI_MISO_O, // spi data out
  output logic SPI_MISO_OE_O, // spi data out enable
  output logic [pmcr_pkg::NPORT-1:0] SOFT_RESET_O, // port held in soft reset
  output logic [pmcr_pkg::NPORT-1:0] MAC_LOOPBACK_O, // mac loopback per port
  output logic [pmcr_pkg::NPORT-1:0] FORCE_100_O, // 1: 100 mbps, 0: 10 mbps
  output logic [pmcr_pkg::NPORT-1:0] AUTONEG_ON_O, // autonegotiation enabled
  output logic [pmcr_pkg::NPORT-1:0] POWER_DOWN_O, // port powered down
  output logic [pmcr_pkg::NPORT-1:0] LINE_ISOLATION_O, // phy isolated from line
  output logic [pmcr_pkg::NPORT-1:0] AUTONEG_RERUN_O, // one-cycle restart pulse
  output logic [pmcr_pkg::NPORT-1:0] FULL_DUPLEX_O, // 1: full, 0: half duplex
  output logic [pmcr_pkg::NPORT-1:0] CROSSOVER_STYLE_SELECT_O // crossover scheme
);
  localparam int NP = pmcr_pkg::NPORT;
  localparam int PW = pmcr_pkg::PW;
  localparam int SW = pmcr_pkg::SRST_W;

  // whole state of the block
  typedef struct packed {
    logic [2:0] sck_s; // [0] first sync flop, [1] second, [2] previous
    logic [1:0] csn_s; // select synchroniser
    logic [1:0] mosi_s; // data synchroniser
    logic [5:0] bcnt; // spi bit counter
    logic [15:0] sh; // spi shift register
    logic [15:0] hdr; // spi command and address
    logic miso; // spi out level
    logic miso_oe; // spi out enable
    logic pend; // spi write waiting to apply
    logic [PW-1:0] pend_port; // its port
    logic [15:0] pend_data; // its word
    logic [NP-1:0][SW-1:0] srst_cnt; // soft reset countdown
    logic [NP-1:0] srst; // soft reset active
    logic [NP-1:0] loop; // mac loopback
    logic [NP-1:0] f100; // forced speed
    logic [NP-1:0] anen; // autoneg_on
    logic [NP-1:0] pdn; // power down
    logic [NP-1:0] iso; // line_isolation
    logic [NP-1:0] anrr; // autoneg_rerun as stored
    logic [NP-1:0] fdx; // forced duplex
    logic [NP-1:0] xsel; // crossover_style_select
    logic [NP-1:0] rerun; // restart pulse
  } pmcr_q_t;

  localparam pmcr_q_t RST_Q = '{
    csn_s: 2'h3,
    f100: {NP{pmcr_pkg::RST_F100}},
    anen: {NP{pmcr_pkg::RST_ANEN}},
    xsel: {NP{pmcr_pkg::RST_XSEL}},
    default: '0
  };

  pmcr_q_t q; // registered state
  pmcr_q_t d; // next state
  logic [NP-1:0][15:0] ctrl_rd; // read view of each control word
  logic [NP-1:0][7:0] fld; // writable fields, for checks
  logic [4:0] m_phy; // management port address
  logic [4:0] m_rg; // management register address
  logic m_wr; // management write strobe
  logic [15:0] m_wdata; // management write word
  logic [15:0] m_rdata; // management read word
  logic m_ctrl_ok; // management access hits a control word
  logic [PW-1:0] m_idx; // management port index
  logic [7:0] s_addr_new; // spi address byte as it completes
  logic [7:0] s_cmd_new; // spi command byte once the address byte completes
  logic [15:0] s_rdata; // spi read word
  logic wr_go; // a control word write applies now
  logic [PW-1:0] wr_idx; // its port
  logic [15:0] wr_dat; // its word
  logic sck_rise; // spi clock rising
  logic sck_fall; // spi clock falling

  // spi map: address {2'b00, port-1, index}, index 6 and 7 for the vendor pair
  function automatic logic spi_ctrl_hit(input logic [7:0] a);
    return (a[7:6] == 2'b00) && (a[5:3] < PW'(NP)) &&
           (pmcr_pkg::spi_idx_to_reg(a[2:0]) == pmcr_pkg::REG_CTRL); // RULE1
  endfunction : spi_ctrl_hit

  // serial management frames
  pmcr_mdio_slave u_mdio (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .mdc_i(MDC_I),
    .mdio_i(MDIO_I),
    .mdio_o(MDIO_O),
    .mdio_oe_o(MDIO_OE_O),
    .phy_o(m_phy),
    .reg_o(m_rg),
    .rdata_i(m_rdata),
    .wr_o(m_wr),
    .wdata_o(m_wdata)
  );

  // address decode; every other known register reads as zero here
  assign m_ctrl_ok = (m_phy >= pmcr_pkg::PHYAD_FIRST) && (m_phy <= pmcr_pkg::PHYAD_LAST) &&
                     (m_rg == pmcr_pkg::REG_CTRL);
  assign m_idx = PW'(m_phy - pmcr_pkg::PHYAD_FIRST); // RULE2
  assign m_rdata = m_ctrl_ok ? ctrl_rd[m_idx] : '0;
  assign s_addr_new = {q.sh[6:0], q.mosi_s[1]};
  assign s_cmd_new = q.sh[14:7];
  assign s_rdata = spi_ctrl_hit(s_addr_new) ? ctrl_rd[s_addr_new[5:3]] : '0; // RULE1
  assign sck_rise = q.sck_s[1] & ~q.sck_s[2];
  assign sck_fall = ~q.sck_s[1] & q.sck_s[2];

  // one write source per cycle; management wins, spi waits a cycle
  always_comb begin
    wr_go = 1'b0;
    wr_idx = '0;
    wr_dat = '0;
    if (m_wr) begin
      wr_go = m_ctrl_ok;
      wr_idx = m_idx;
      wr_dat = m_wdata;
    end else if (q.pend) begin
      wr_go = 1'b1;
      wr_idx = q.pend_port;
      wr_dat = q.pend_data;
    end
  end

  // per port read view and field vector
  for (genvar p = 0; p < NP; p++) begin : g_port
    always_comb begin
      // collision test and reserved stay zero
      ctrl_rd[p] = '0; // RULE14
      ctrl_rd[p][pmcr_pkg::B_SRST] = q.srst[p]; // RULE4
      ctrl_rd[p][pmcr_pkg::B_LOOP] = q.loop[p];
      ctrl_rd[p][pmcr_pkg::B_F100] = q.f100[p];
      ctrl_rd[p][pmcr_pkg::B_ANEN] = q.anen[p];
      ctrl_rd[p][pmcr_pkg::B_PDN] = q.pdn[p];
      ctrl_rd[p][pmcr_pkg::B_ISO] = q.iso[p];
      ctrl_rd[p][pmcr_pkg::B_ANRR] = q.anrr[p];
      ctrl_rd[p][pmcr_pkg::B_FDX] = q.fdx[p];
      ctrl_rd[p][pmcr_pkg::B_XSEL] = q.xsel[p];
    end
    assign fld[p] = {q.loop[p], q.f100[p], q.anen[p], q.pdn[p],
                     q.iso[p], q.anrr[p], q.fdx[p], q.xsel[p]};

    a_srst_defaults: assert property ( // RULE4 RULE15
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (wr_go && wr_idx == PW'(p) && wr_dat[pmcr_pkg::B_SRST])
      |=> (q.srst[p] && ctrl_rd[p][pmcr_pkg::B_SRST] && !q.loop[p] && q.f100[p] &&
           q.anen[p] && !q.pdn[p] && !q.iso[p] && !q.anrr[p] && !q.fdx[p] && q.xsel[p]))
      else $error("soft reset did not restore the defaults");

    a_srst_clears: assert property ( // RULE4
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (q.srst_cnt[p] == SW'(1) && !(wr_go && wr_idx == PW'(p) && wr_dat[pmcr_pkg::B_SRST]))
      |=> !q.srst[p] ##1 !SOFT_RESET_O[p])
      else $error("soft reset bit did not clear");

    a_field_write: assert property ( // RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE12 RULE13
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (wr_go && wr_idx == PW'(p) && !wr_dat[pmcr_pkg::B_SRST] && !q.srst[p])
      |=> (MAC_LOOPBACK_O[p] == $past(wr_dat[pmcr_pkg::B_LOOP])) &&
          (FORCE_100_O[p] == $past(wr_dat[pmcr_pkg::B_F100])) &&
          (AUTONEG_ON_O[p] == $past(wr_dat[pmcr_pkg::B_ANEN])) &&
          (POWER_DOWN_O[p] == $past(wr_dat[pmcr_pkg::B_PDN])) &&
          (LINE_ISOLATION_O[p] == $past(wr_dat[pmcr_pkg::B_ISO])) &&
          (FULL_DUPLEX_O[p] == $past(wr_dat[pmcr_pkg::B_FDX])) &&
          (CROSSOVER_STYLE_SELECT_O[p] == $past(wr_dat[pmcr_pkg::B_XSEL])))
      else $error("control write did not reach the port");

    a_port_steer: assert property ( // RULE2
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (m_wr && m_phy != (pmcr_pkg::PHYAD_FIRST + 5'(p))) |=> ($stable(fld[p]) && !q.rerun[p]))
      else $error("write changed a port it did not address");

    a_rerun_cause: assert property ( // RULE11
      @(posedge MCLK_I) disable iff (!RESETN_I)
      AUTONEG_RERUN_O[p] |-> ($past(wr_go) && $past(wr_idx) == PW'(p) &&
                              $past(wr_dat[pmcr_pkg::B_ANRR]) && !$past(q.srst[p])))
      else $error("restart pulse without a restart write");

    a_rsvd_zero: assert property ( // RULE14
      @(posedge MCLK_I) disable iff (!RESETN_I)
      !ctrl_rd[p][pmcr_pkg::B_COLT] && !ctrl_rd[p][pmcr_pkg::B_RSVD])
      else $error("collision test or reserved bit reads one");
  end

  // next state: spi frames, write apply, soft reset countdown
  always_comb begin
    d = q;
    d.rerun = '0;
    d.pend = 1'b0; // a waiting write applies when management is idle
    if (m_wr) d.pend = q.pend;
    d.sck_s = {q.sck_s[1:0], SPI_SCLK_I};
    d.csn_s = {q.csn_s[0], SPI_CS_N_I};
    d.mosi_s = {q.mosi_s[0], SPI_MOSI_I};
    // spi mode 0: sample on rise, shift out on fall
    if (q.csn_s[1]) begin // deselected, clear the frame
      d.bcnt = '0;
      d.hdr = '0;
      d.miso = 1'b0;
      d.miso_oe = 1'b0;
    end else begin
      d.miso_oe = 1'b1;
      if (sck_rise && q.bcnt != pmcr_pkg::SPI_ALL) begin // extra bits ignored
        d.bcnt = q.bcnt + 6'h01;
        if (q.bcnt <= pmcr_pkg::SPI_HDR_LAST || q.hdr[15:8] == pmcr_pkg::CMD_WR) begin
          d.sh = {q.sh[14:0], q.mosi_s[1]};
        end
        if (q.bcnt == pmcr_pkg::SPI_HDR_LAST) begin
          d.hdr = {q.sh[14:0], q.mosi_s[1]};
          if (s_cmd_new == pmcr_pkg::CMD_RD) d.sh = s_rdata; // RULE1
        end
        if (q.bcnt == pmcr_pkg::SPI_DAT_LAST && q.hdr[15:8] == pmcr_pkg::CMD_WR &&
            spi_ctrl_hit(q.hdr[7:0])) begin // RULE1
          d.pend = 1'b1;
          d.pend_port = q.hdr[5:3];
          d.pend_data = {q.sh[14:0], q.mosi_s[1]};
        end
      end
      if (sck_fall && q.bcnt > pmcr_pkg::SPI_HDR_LAST && q.hdr[15:8] == pmcr_pkg::CMD_RD) begin
        d.miso = q.sh[15];
        d.sh = {q.sh[14:0], 1'b0};
      end
    end
    // per port control words
    for (int p = 0; p < NP; p++) begin
      if (q.srst_cnt[p] != '0) d.srst_cnt[p] = q.srst_cnt[p] - SW'(1);
      if (wr_go && wr_idx == PW'(p)) begin
        if (wr_dat[pmcr_pkg::B_SRST]) begin // defaults first, bit clears later
          d.loop[p] = pmcr_pkg::RST_LOOP; // RULE15
          d.f100[p] = pmcr_pkg::RST_F100;
          d.anen[p] = pmcr_pkg::RST_ANEN;
          d.pdn[p] = pmcr_pkg::RST_PDN;
          d.iso[p] = pmcr_pkg::RST_ISO;
          d.anrr[p] = pmcr_pkg::RST_ANRR;
          d.fdx[p] = pmcr_pkg::RST_FDX;
          d.xsel[p] = pmcr_pkg::RST_XSEL;
          d.srst_cnt[p] = SW'(pmcr_pkg::SRST_CYC); // RULE4
        end else if (!q.srst[p]) begin // writes during soft reset are dropped
          d.loop[p] = wr_dat[pmcr_pkg::B_LOOP]; // RULE5 RULE6
          d.f100[p] = wr_dat[pmcr_pkg::B_F100]; // RULE7
          d.anen[p] = wr_dat[pmcr_pkg::B_ANEN]; // RULE8
          d.pdn[p] = wr_dat[pmcr_pkg::B_PDN]; // RULE9
          d.iso[p] = wr_dat[pmcr_pkg::B_ISO]; // RULE10
          d.anrr[p] = wr_dat[pmcr_pkg::B_ANRR];
          d.rerun[p] = wr_dat[pmcr_pkg::B_ANRR]; // RULE11
          d.fdx[p] = wr_dat[pmcr_pkg::B_FDX]; // RULE12
          d.xsel[p] = wr_dat[pmcr_pkg::B_XSEL]; // RULE13
        end
      end
      d.srst[p] = (d.srst_cnt[p] != '0); // RULE4
    end
  end

  // state register
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      q <= RST_Q;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign SPI_MISO_O = q.miso;
  assign SPI_MISO_OE_O = q.miso_oe;
  assign SOFT_RESET_O = q.srst;
  assign MAC_LOOPBACK_O = q.loop;
  assign FORCE_100_O = q.f100;
  assign AUTONEG_ON_O = q.anen;
  assign POWER_DOWN_O = q.pdn;
  assign LINE_ISOLATION_O = q.iso;
  assign AUTONEG_RERUN_O = q.rerun;
  assign FULL_DUPLEX_O = q.fdx;
  assign CROSSOVER_STYLE_SELECT_O = q.xsel;

  a_spi_write: assert property ( // RULE1
    @(posedge MCLK_I) disable iff (!RESETN_I)
    (q.pend && !m_wr && !q.srst[q.pend_port] && !q.pend_data[pmcr_pkg::B_SRST])
    |=> (ctrl_rd[$past(q.pend_port)] == ($past(q.pend_data) &
         ~(16'h0001 << pmcr_pkg::B_COLT) & ~(16'h0001 << pmcr_pkg::B_RSVD) & 16'h7fe0)) &&
        !q.pend)
    else $error("spi write did not land in the addressed port");
endmodule : pmcr_phy_ctrl

// File: pmcr_host_model.sv
// management host model that drives mdc and mdio frames
`timescale 1ns/1ps
module pmcr_host_model (
  input wire logic clk_i, // system clock
  input wire logic mdio_i, // resolved wire level
  output logic mdc_o, // management clock
  output logic md_o, // level driven on the wire
  output logic oe_o // high while driving
);
  // idle: clock low, wire released
  initial begin
    mdc_o = 1'b0;
    md_o = 1'b1;
    oe_o = 1'b0;
  end
  // one mdc period, 5 low and 4 high, so each phase exceeds 3 clocks
  task automatic cyc(input logic b, input logic d, output logic s);
    @(posedge clk_i) mdc_o <= 1'b0;
    md_o <= b;
    oe_o <= d;
    repeat (5) @(posedge clk_i);
    s = mdio_i; // sampled just before the rise
    mdc_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : cyc
  // whole frame; a read releases the wire from turnaround on
  task automatic frame(input logic rd, input logic [4:0] ph, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic s;
    logic [13:0] h;
    h = {2'b01, rd ? 2'b10 : 2'b01, ph, rg};
    repeat (32) cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(h[i], 1'b1, s);
    cyc(!rd, !rd, s);
    cyc(1'b0, !rd, s);
    for (int i = 15; i >= 0; i--) begin
      cyc(wd[i], !rd, s);
      rdat[i] = s;
    end
    cyc(1'b1, 1'b0, s); // release, then let the write land
    repeat (8) @(posedge clk_i);
  endtask : frame
endmodule : pmcr_host_model

// File: tb_top.sv
// self-checking bench for the port phy control words
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin \
  $display("BAD t=%0t got %h exp %h", $time, a, e); err_count++; end end
module tb_top;
  logic mclk, rst_n, h_mdc, h_md, h_oe, d_md, d_oe, sclk, cs_n, mosi, miso, mso_oe, mdio_w;
  logic [4:0] srst, loop, f100, anen, pdn, iso, rr, fdx, xsel, m, nm;
  logic [4:0] rr_seen = 5'h00; // sticky copy of the restart pulses
  logic [15:0] rd;
  logic [39:0] st, ex;
  int err_count = 0;
  int n_checks = 0;
  assign st = {srst, loop, f100, anen, pdn, iso, fdx, xsel};
  assign mdio_w = d_oe ? d_md : (h_oe ? h_md : 1'b1); // pull-up when released
  pmcr_host_model HOST (.clk_i(mclk), .mdio_i(mdio_w), .mdc_o(h_mdc), .md_o(h_md), .oe_o(h_oe));
  pmcr_phy_ctrl DUT (.MCLK_I(mclk), .RESETN_I(rst_n), .MDC_I(h_mdc), .MDIO_I(mdio_w),
    .MDIO_O(d_md), .MDIO_OE_O(d_oe), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(mso_oe), .SOFT_RESET_O(srst),
    .MAC_LOOPBACK_O(loop), .FORCE_100_O(f100), .AUTONEG_ON_O(anen), .POWER_DOWN_O(pdn),
    .LINE_ISOLATION_O(iso), .AUTONEG_RERUN_O(rr), .FULL_DUPLEX_O(fdx),
    .CROSSOVER_STYLE_SELECT_O(xsel));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // cleared in reset so the unknown state before the first edge cannot stick
  always @(posedge mclk) rr_seen <= rst_n ? (rr_seen | rr) : 5'h00;
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] w);
    HOST.frame(1'b0, p, r, w, rd);
  endtask : wr
  task automatic rdk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
    HOST.frame(1'b1, p, r, 16'h0000, rd);
    `CHK(rd, e);
  endtask : rdk
  // one spi mode 0 access; slow phases cover the pin synchronisers
  task automatic spi(input logic [7:0] c, input logic [7:0] a, input logic [15:0] w);
    logic [31:0] f;
    f = {c, a, w};
    rd = 16'h0000;
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      repeat (3) @(posedge mclk);
      sclk <= 1'b0;
      mosi <= f[i];
      repeat (6) @(posedge mclk);
      if (i < 16) rd[i] = miso;
      if (i == 16) `CHK(mso_oe, 1'b1);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge mclk);
    sclk <= 1'b0;
    cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : spi
  initial begin
    #400000;
    err_count++;
    report_and_stop;
  end
  initial begin
    rst_n = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    `CHK(st, {10'h0, 5'h1f, 5'h1f, 15'h0, 5'h1f});
    `CHK({mso_oe, d_oe}, 2'b00);
    rdk(5'h01, 5'h00, 16'h3020);
    $display("test defaults done");
    for (int p = 1; p <= 5; p++) begin
      wr(5'(p), 5'h00, 16'h4dc0);
      m = 5'((1 << p) - 1);
      nm = ~m;
      ex = {5'h0, m, nm, nm, m, m, m, nm};
      `CHK(st, ex);
      rdk(5'(p), 5'h00, 16'h4d00);
    end
    $display("test ports done");
    wr(5'h06, 5'h00, 16'h0000);
    wr(5'h01, 5'h02, 16'h0000);
    rdk(5'h01, 5'h06, 16'hffff);
    rdk(5'h01, 5'h1d, 16'h0000);
    `CHK(st, ex);
    $display("test refusals done");
    wr(5'h03, 5'h00, 16'h0200);
    `CHK(rr_seen, 5'h04);
    wr(5'h03, 5'h00, 16'h8000);
    `CHK({srst, f100, anen, pdn}, {5'h04, 5'h04, 5'h04, 5'h1b});
    repeat (150) @(posedge mclk);
    `CHK(srst, 5'h04);
    repeat (100) @(posedge mclk);
    `CHK(srst, 5'h00);
    rdk(5'h03, 5'h00, 16'h3020);
    $display("test soft reset done");
    spi(8'h02, 8'h08, 16'h3000);
    `CHK({loop, fdx}, {5'h19, 5'h19});
    spi(8'h03, 8'h08, 16'h0000);
    `CHK(rd, 16'h3000);
    spi(8'h03, 8'h28, 16'h0000);
    `CHK(rd, 16'h0000);
    rdk(5'h02, 5'h00, 16'h3000);
    $display("test spi done");
    report_and_stop;
  end
endmodule : tb_top
